// *** inc/tfa_pkg.sv ***
// Package for the thermal and fan alert status and mask block
package tfa_pkg;
  // Register word indices, matched against paddr[9:2] (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_CONFIG_ONE  = 8'h01;
  localparam logic [7:0] IDX_MASK_SENSOR = 8'h08;
  localparam logic [7:0] IDX_MASK_OVHT   = 8'h09;
  localparam logic [7:0] IDX_MASK_COOL   = 8'h0a;
  localparam logic [7:0] IDX_FLAG_SENSOR = 8'h4f;
  localparam logic [7:0] IDX_FLAG_OVHT   = 8'h50;
  localparam logic [7:0] IDX_FLAG_COOL   = 8'h51;
  localparam logic [7:0] IDX_COND_VIEW   = 8'h60;
  localparam int         ADDR_LSB        = 2;

  // Field positions and writable masks
  localparam int         CFG_COMP_BIT     = 3;
  localparam int         OVHT_PIN_BIT     = 2;
  localparam int         COOL_LINE_BIT    = 0;
  localparam logic [7:0] SENSOR_VALID     = 8'hff;
  localparam logic [7:0] OVHT_VALID       = 8'hfc;
  localparam logic [7:0] OVHT_MASK_VALID  = 8'h1c;
  localparam logic [7:0] COOL_VALID       = 8'he0;
  localparam logic [7:0] COOL_MASK_VALID  = 8'he0;
  localparam logic [7:0] CFG_VALID        = 8'h08;

  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;

  // Raw conditions from the surrounding monitor
  typedef struct packed {
    logic [7:0] sensor;  // local_high_exceeded .. remote_two_diode_fault
    logic [7:0] ovht;    // crit, percent, overheat_line_driven, pin level
    logic [7:0] cooler;  // cooler1_stalled, alarm rate, cooler2_stalled
  } tfa_cond_t;

  typedef enum logic {
    TFA_MODE_LATCHED,
    TFA_MODE_COMPARATOR
  } tfa_mode_t;
endpackage : tfa_pkg

// *** src/tfa_alert_status.sv ***
// Alert status latching, masking and alert line drive with APB access
//
// Summary of operation
// - Sensor flags: local/remote high, low, diode.
// - Overheat flags: crit, percent, line driven.
// - Pin level bit clears only when inactive.
// - Cooler flags: stalls and alarm speed.
// - Bit 0 shows alert line driven low.
// - Alert on unmasked out-of-limit condition.
// - Config bit 3 selects latched or comparator.
// - Latched: set flag, drive alert if unmasked.
// - Latched alert releases on read or response.
// - Comparator: alert follows unmasked conditions live.
// - Masks gate alert only, flags still set.
// - Sensor mask bits match sensor flag bits.
// - Overheat mask bits 4, 3, 2 only.
// - Pin-level mask ignored in comparator mode.
// - Cooler mask bits 7, 6, 5 only.
// - Flags sticky; clear on read after condition.
// - High uses >=, low uses < comparison.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module tfa_alert_status (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire tfa_pkg::tfa_cond_t cond,
  input  wire logic              alert_resp_done,
  input  wire logic              alert_line_in,
  output logic                   alert_line_out,
  output logic                   alert_line_oe
);
  logic [7:0] mask_sensor_limits;
  logic [7:0] mask_overheat_events;
  logic [7:0] mask_cooler_events;
  logic [7:0] sensor_limit_flags;
  logic [7:0] overheat_flags;
  logic [7:0] cooler_flags;
  logic [7:0] config_one;
  logic       alert_latched;
  tfa_pkg::tfa_mode_t mode;

  logic [7:0] cond_sensor;
  logic [7:0] cond_ovht;
  logic [7:0] cond_cool;
  logic [7:0] word_idx;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic       rd_sensor;
  logic       rd_ovht;
  logic       rd_cool;
  logic [7:0] pend_sensor;
  logic [7:0] pend_ovht;
  logic [7:0] pend_cool;
  logic [7:0] live_ovht_mask;
  logic       any_live;
  logic       any_pending;
  logic [23:0] pend_seen;
  logic       alert_drive;
  logic [7:0] rd_byte;

  // Conditions already compared upstream with >= high, < low limits
  assign cond_sensor = cond.sensor & tfa_pkg::SENSOR_VALID;
  assign cond_ovht   = cond.ovht & tfa_pkg::OVHT_VALID;
  assign cond_cool   = cond.cooler & tfa_pkg::COOL_VALID;

  // APB decode; zero wait states
  assign word_idx  = paddr[9:2];
  assign acc       = psel & penable;
  assign wr        = acc & pwrite & pstrb[0];
  assign rd        = acc & ~pwrite;
  assign pready    = 1'b1;
  assign rd_sensor = rd & (word_idx == tfa_pkg::IDX_FLAG_SENSOR);
  assign rd_ovht   = rd & (word_idx == tfa_pkg::IDX_FLAG_OVHT);
  assign rd_cool   = rd & (word_idx == tfa_pkg::IDX_FLAG_COOL);

  always_comb begin
    case (word_idx)
      tfa_pkg::IDX_CONFIG_ONE,
      tfa_pkg::IDX_MASK_SENSOR,
      tfa_pkg::IDX_MASK_OVHT,
      tfa_pkg::IDX_MASK_COOL,
      tfa_pkg::IDX_FLAG_SENSOR,
      tfa_pkg::IDX_FLAG_OVHT,
      tfa_pkg::IDX_FLAG_COOL,
      tfa_pkg::IDX_COND_VIEW: hit = 1'b1;
      default:                hit = 1'b0;
    endcase
  end
  assign pslverr = acc & ~hit;

  assign mode = config_one[tfa_pkg::CFG_COMP_BIT] ?
                tfa_pkg::TFA_MODE_COMPARATOR : tfa_pkg::TFA_MODE_LATCHED;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_one <= tfa_pkg::CFG_RESET;
    end else if (wr && word_idx == tfa_pkg::IDX_CONFIG_ONE) begin
      config_one <= pwdata[7:0] & tfa_pkg::CFG_VALID;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sensor_limits   <= tfa_pkg::MASK_RESET;
      mask_overheat_events <= tfa_pkg::MASK_RESET;
      mask_cooler_events   <= tfa_pkg::MASK_RESET;
    end else if (wr) begin
      if (word_idx == tfa_pkg::IDX_MASK_SENSOR)
        mask_sensor_limits <= pwdata[7:0];
      if (word_idx == tfa_pkg::IDX_MASK_OVHT)
        mask_overheat_events <= pwdata[7:0] & tfa_pkg::OVHT_MASK_VALID;
      if (word_idx == tfa_pkg::IDX_MASK_COOL)
        mask_cooler_events <= pwdata[7:0] & tfa_pkg::COOL_MASK_VALID;
    end
  end

  // Sticky flags: a read clears only bits whose condition is gone and
  // that the read actually reported; a bit set after the setup-cycle
  // snapshot survives the read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_limit_flags <= tfa_pkg::FLAG_RESET;
    end else if (rd_sensor) begin
      sensor_limit_flags <= cond_sensor |
                            (sensor_limit_flags & ~prdata[7:0]);
    end else begin
      sensor_limit_flags <= sensor_limit_flags | cond_sensor;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overheat_flags <= tfa_pkg::FLAG_RESET;
    end else if (rd_ovht) begin
      overheat_flags <= cond_ovht |
                        (overheat_flags & ~prdata[7:0]);
    end else begin
      overheat_flags <= overheat_flags | cond_ovht;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cooler_flags <= tfa_pkg::FLAG_RESET;
    end else if (rd_cool) begin
      cooler_flags <= cond_cool |
                      (cooler_flags & ~prdata[7:0]);
    end else begin
      cooler_flags <= cooler_flags | cond_cool;
    end
  end

  // Pin-level source never alerts in comparator mode, so its mask is moot
  always_comb begin
    live_ovht_mask = mask_overheat_events;
    if (mode == tfa_pkg::TFA_MODE_COMPARATOR)
      live_ovht_mask[tfa_pkg::OVHT_PIN_BIT] = 1'b1;
  end

  assign any_live = |(cond_sensor & ~mask_sensor_limits) |
                    |(cond_ovht & ~live_ovht_mask) |
                    |(cond_cool & ~mask_cooler_events);
  assign pend_sensor = sensor_limit_flags & ~mask_sensor_limits;
  assign pend_ovht   = overheat_flags & ~mask_overheat_events;
  assign pend_cool   = cooler_flags & ~mask_cooler_events;
  // Only newly pending sources re-raise; a still-set flag alone must not
  // undo a release by read or response cycle
  assign any_pending = |({pend_sensor, pend_ovht, pend_cool} & ~pend_seen);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_seen <= 24'h00_0000;
    end else begin
      pend_seen <= {pend_sensor, pend_ovht, pend_cool};
    end
  end

  // Latched alert: set by new unmasked event, released by a status read or
  // response cycle unless an unmasked source is still out of limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_latched <= 1'b0;
    end else if (any_live) begin
      alert_latched <= 1'b1;
    end else if (rd_sensor || rd_ovht || rd_cool || alert_resp_done) begin
      alert_latched <= 1'b0;
    end else if (any_pending && !alert_latched) begin
      // Unmasking a still-set flag re-raises the line
      alert_latched <= 1'b1;
    end
  end

  assign alert_drive = (mode == tfa_pkg::TFA_MODE_COMPARATOR) ?
                       any_live : alert_latched;
  // Open-drain: only ever drives low
  assign alert_line_out = 1'b0;
  assign alert_line_oe  = alert_drive;

  always_comb begin
    case (word_idx)
      tfa_pkg::IDX_CONFIG_ONE:  rd_byte = config_one;
      tfa_pkg::IDX_MASK_SENSOR: rd_byte = mask_sensor_limits;
      tfa_pkg::IDX_MASK_OVHT:   rd_byte = mask_overheat_events;
      tfa_pkg::IDX_MASK_COOL:   rd_byte = mask_cooler_events;
      tfa_pkg::IDX_FLAG_SENSOR: rd_byte = sensor_limit_flags;
      tfa_pkg::IDX_FLAG_OVHT:   rd_byte = overheat_flags;
      tfa_pkg::IDX_FLAG_COOL:   rd_byte = cooler_flags |
                                  {7'h00, alert_drive};
      tfa_pkg::IDX_COND_VIEW:   rd_byte = {7'h00, ~alert_line_in};
      default:                  rd_byte = 8'h00;
    endcase
  end

  // Read data registered in setup cycle so it is valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end
endmodule : tfa_alert_status

// *** testbench/tfa_alert_status_bench.sv ***
// Self-checking bench for the alert status block
`timescale 1ns/1ps
module tfa_alert_status_bench;
  typedef struct packed {
    logic [7:0]         m1, m2, m3;
    tfa_pkg::tfa_cond_t c;
    logic               oe;
  } tfa_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ara_req = 1'b0, pready, pslverr, oe, lo, li, rsp, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] q;
  tfa_pkg::tfa_cond_t cond = '0;
  int miscompares = 0, n_compared = 0;
  tfa_row_t rows [8];
  always #5 pclk = !pclk;
  tfa_alert_status i_tfa_alert_status (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'h1), .prdata, .pready, .pslverr,
    .cond, .alert_resp_done(rsp), .alert_line_in(li),
    .alert_line_out(lo), .alert_line_oe(oe));
  tfa_host i_tfa_host (.pclk, .alert_line_oe(oe), .alert_line_out(lo),
    .ara_req, .alert_line_in(li), .alert_resp_done(rsp));
  task cmp(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask : cmp
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    cmp(q, x);
  endtask : rd
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    #50us;
    miscompares++;
    wrap_up();
  end
  initial begin
    rows = '{{8'h00, 8'h00, 8'h00, 24'h800000, 1'b1},
             {8'h80, 8'h00, 8'h00, 24'h800000, 1'b0},
             {8'hfe, 8'h00, 8'h00, 24'h010000, 1'b1},
             {8'h00, 8'hff, 8'h00, 24'h000400, 1'b0},
             {8'h00, 8'h10, 8'h00, 24'h001000, 1'b0},
             {8'h00, 8'h10, 8'h00, 24'h000800, 1'b1},
             {8'h00, 8'h00, 8'ha0, 24'h000040, 1'b1},
             {8'h00, 8'h00, 8'hff, 24'h0003ff, 1'b0}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++)
      rd(k < 3 ? 12'h020 + 12'(4 * k) : 12'h130 + 12'(4 * k), 8'h00);
    $display("reset test done");
    apb(1'b1, 12'h004, 8'h08);
    foreach (rows[i]) begin
      apb(1'b1, 12'h020, rows[i].m1);
      apb(1'b1, 12'h024, rows[i].m2);
      apb(1'b1, 12'h028, rows[i].m3);
      rd(12'h024, rows[i].m2 & 8'h1c);
      rd(12'h028, rows[i].m3 & 8'he0);
      cond <= rows[i].c;
      @(posedge pclk);
      #1;
      cmp({7'h0, oe}, {7'h0, rows[i].oe});
      rd(12'h13c, rows[i].c.sensor);
      rd(12'h140, rows[i].c.ovht & 8'hfc);
      rd(12'h144, rows[i].c.cooler & 8'he0 | {7'h0, rows[i].oe});
      cond <= '0;
      // Clearing reads keep each row free of earlier sticky flags
      for (int k = 0; k < 3; k++) apb(1'b0, 12'h13c + 12'(4 * k), 8'h00);
    end
    $display("table test done");
    apb(1'b1, 12'h004, 8'h00);
    cond.sensor <= 8'h40;
    @(posedge pclk);
    cond.sensor <= 8'h00;
    repeat (2) @(posedge pclk);
    #1;
    cmp({7'h0, oe}, 8'h01);
    rd(12'h180, 8'h01);
    rd(12'h13c, 8'h40);
    #1;
    cmp({7'h0, oe}, 8'h00);
    @(posedge pclk);
    cond.sensor <= 8'h01;
    @(posedge pclk);
    cond.sensor <= 8'h00;
    @(posedge pclk);
    ara_req <= 1'b1;
    @(posedge pclk);
    ara_req <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    cmp({7'h0, oe}, 8'h00);
    apb(1'b0, 12'h13c, 8'h00);
    $display("latched test done");
    cond.sensor <= 8'h04;
    rd(12'h13c, 8'h04);
    apb(1'b1, 12'h020, 8'h04);
    rd(12'h13c, 8'h04);
    #1;
    cmp({7'h0, oe}, 8'h00);
    @(posedge pclk);
    cond.sensor <= 8'h00;
    rd(12'h13c, 8'h04);
    rd(12'h13c, 8'h00);
    apb(1'b1, 12'h020, 8'h00);
    apb(1'b0, 12'h0fc, 8'h00);
    cmp({7'h0, e}, 8'h01);
    cmp(q, 8'h00);
    #1;
    cmp({7'h0, oe}, 8'h00);
    $display("service test done");
    wrap_up();
  end
endmodule : tfa_alert_status_bench

// *** testbench/tfa_host.sv ***
// Host side of the alert wire: pull-up and response cycle
`timescale 1ns/1ps
module tfa_host (
  input  wire logic pclk,
  input  wire logic alert_line_oe,
  input  wire logic alert_line_out,
  input  wire logic ara_req,
  output logic      alert_line_in,
  output logic      alert_resp_done
);
  // Pull-up lifts the wire whenever the device lets go
  assign alert_line_in = alert_line_oe ? alert_line_out : 1'b1;
  initial alert_resp_done = 1'b0;
  // Responds only while the wire is low, as a real responder would
  always @(posedge pclk) alert_resp_done <= ara_req && !alert_line_in;
endmodule : tfa_host

// *** testbench/tfa_props.sv ***
// Checker for the alert line and read data
`timescale 1ns/1ps
module tfa_props (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire tfa_pkg::tfa_cond_t cond,
  input wire logic               alert_resp_done,
  input wire logic               alert_line_out,
  input wire logic               alert_line_oe
);
  logic       acc, wr, comp;
  logic [7:0] msk;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  // Mirrors of mode and sensor mask, updated at the write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) comp <= 1'b0;
    else if (wr && paddr == 12'h004) comp <= pwdata[3];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) msk <= 8'h00;
    else if (wr && paddr == 12'h020) msk <= pwdata[7:0];
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_open_drain: assert property (alert_line_out == 1'b0)
    else $error("alert pin driven high");
  a_latch_set: assert property (!comp && !wr && |(cond.sensor & ~msk)
    |=> alert_line_oe) else $error("latched alert not set");
  a_latch_hold: assert property (!comp && !acc && !alert_resp_done
    && alert_line_oe |=> alert_line_oe) else $error("latched alert lost");
  a_comp_set: assert property (comp && |(cond.sensor & ~msk)
    |-> alert_line_oe) else $error("comparator alert missing");
  a_comp_pin: assert property (comp && cond.ovht[7:3] == 5'h00
    && cond.sensor == 8'h00 && cond.cooler[7:5] == 3'h0 |-> !alert_line_oe)
    else $error("comparator alert without source");
  a_unmapped: assert property (acc && paddr == 12'h0fc |-> pslverr)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (acc && !pwrite
    |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_resv_ovht: assert property (acc && !pwrite && paddr == 12'h140
    |-> prdata[1:0] == 2'b00) else $error("reserved bits set");
endmodule : tfa_props
bind tfa_alert_status tfa_props i_tfa_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .cond,
  .alert_resp_done, .alert_line_out, .alert_line_oe);
